// *** rtl/cdt_defs.vh ***
`ifndef CDT_DEFS_VH
`define CDT_DEFS_VH

// ==========================================================
// Register byte offsets
`define CDT_OFS_CMP1_CTRL 4'h0
`define CDT_OFS_CMP0_TRIM 4'h4
`define CDT_OFS_CMP1_TRIM 4'h8
`define CDT_OFS_CMP1_POL 4'hc

// ==========================================================
// Reset values
`define CDT_RST_CMP1_CTRL 8'h00
`define CDT_RST_TRIM 8'h10
`define CDT_RST_POL 8'h00

// ==========================================================
// Comparator 1 control fields
`define CDT_CTRL_RAW 7
`define CDT_CTRL_ON 6
`define CDT_CTRL_FILT 5
`define CDT_CTRL_FLEN_HI 3
`define CDT_CTRL_FLEN_LO 2
`define CDT_CTRL_BIAS_HI 1
`define CDT_CTRL_BIAS_LO 0

// ==========================================================
// Trim register fields
`define CDT_TRIM_MODE 6
`define CDT_TRIM_REF 5
`define CDT_TRIM_CODE_HI 4
`define CDT_TRIM_CODE_LO 0

// ==========================================================
// Polarity register fields
`define CDT_POL_INV 0

// ==========================================================
// Bits that are never stored and always read 0
`define CDT_CTRL_GAP 4
`define CDT_TRIM_GAP 7
`define CDT_POL_GAP_HI 7
`define CDT_POL_GAP_LO 1

// ==========================================================
// Filter length selections and prior-sample counts
`define CDT_FLEN_NONE 2'h0
`define CDT_FLEN_SHORT 2'h1
`define CDT_FLEN_MID 2'h2
`define CDT_FLEN_LONG 2'h3
`define CDT_RUN_NONE 7'h00
`define CDT_RUN_SHORT 7'h1f
`define CDT_RUN_MID 7'h3f
`define CDT_RUN_LONG 7'h7e

`endif

// *** rtl/cdt_sync.v ***
`timescale 1ns/100ps
`default_nettype none

module cdt_sync (
  input wire clk_in,
  input wire resetn_in,
  input wire async_in,
  output wire sync_out
);

  reg meta_q;
  reg sync_q;

  // ==========================================================
  // Two-stage synchroniser for the comparator level
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// *** rtl/cdt_filter.v ***
`timescale 1ns/100ps
`default_nettype none

module cdt_filter #(
  parameter RUN_W = 7
) (
  input wire clk_in,
  input wire resetn_in,
  input wire sample_in,
  input wire active_level_in,
  input wire [RUN_W-1:0] run_len_in,
  output wire filt_out
);

  reg [RUN_W-1:0] run_q;
  reg [RUN_W-1:0] run_d;
  reg filt_q;
  reg filt_d;
  wire hit;

  assign hit = (sample_in == active_level_in);

  // ==========================================================
  // Count of prior samples at the active level, saturating
  always @* begin
    run_d = run_q;
    if (!hit) begin
      run_d = {RUN_W{1'b0}};
    end else if (run_q != {RUN_W{1'b1}}) begin
      run_d = run_q + {{(RUN_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Active level only when current and prior run all match
  always @* begin
    if (hit && (run_q >= run_len_in)) begin
      filt_d = active_level_in;
    end else begin
      filt_d = ~active_level_in;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_q <= {RUN_W{1'b0}};
      filt_q <= 1'b0;
    end else begin
      run_q <= run_d;
      filt_q <= filt_d;
    end
  end

  assign filt_out = filt_q;

endmodule

`default_nettype wire

// *** rtl/cdt_top.v ***
// How it works
// - Raw result is 1 when positive input exceeds negative; invert reverses it.
// - Comparator switched off forces its output 0; raw result then equals invert.
// - Invert clear: filtered output high only if current and N prior samples are 1.
// - Invert set: filtered output low only if current and N prior samples are 0.
// - Filter length select: none, 31-32, 63-64 or 126-127 clock periods.
// - Comparator 0 mode bit: 0 normal compare, 1 offset calibration.
// - Comparator 0 holds a writable 5-bit offset trim code.
// - Comparator 1 mode bit and reference select, negative (0) or positive (1).
// - Comparator 1 polarity bit: 0 plain, 1 inverted raw result.
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "cdt_defs.vh"

module cdt_top #(
  parameter RUN_W = 7
) (
  input wire clk_in,
  input wire resetn_in,
  // Avalon-MM slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // Analogue comparator 1
  input wire cmp1_compare_in,
  output wire cmp1_switch_on_out,
  output wire [1:0] cmp1_bias_current_sel_out,
  output wire cmp1_trim_mode_sel_out,
  output wire cmp1_trim_ref_sel_out,
  output wire [4:0] cmp1_trim_code_out,
  output wire cmp1_raw_result_out,
  output wire cmp1_filtered_result_out,
  // Analogue comparator 0 calibration
  output wire cmp0_trim_mode_sel_out,
  output wire cmp0_trim_ref_sel_out,
  output wire [4:0] cmp0_trim_code_out
);

  // ==========================================================
  // Declarations
  reg ack_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  reg [7:0] trim0_q;
  reg [7:0] trim0_d;
  reg [7:0] trim1_q;
  reg [7:0] trim1_d;
  reg [7:0] pol_q;
  reg [7:0] pol_d;
  reg raw_q;
  reg raw_d;
  reg [RUN_W-1:0] run_len;
  wire req;
  wire wr_take;
  wire rd_take;
  wire cmp_sync;
  wire cmp_forced;
  wire inv_sel;
  wire filt;
  wire [7:0] ctrl_view;
  wire [7:0] trim0_view;
  wire [7:0] trim1_view;
  wire [7:0] pol_view;

  // ==========================================================
  // Address match on an aligned byte offset
  function hit_at;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      hit_at = (addr == ofs);
    end
  endfunction

  // Byte-lane merge of the low byte of a register
  function [7:0] lane0;
    input [7:0] old;
    input [31:0] wdata;
    input [3:0] be;
    begin
      if (be[0]) begin
        lane0 = wdata[7:0];
      end else begin
        lane0 = old;
      end
    end
  endfunction

  // Read view of a trim register; top bit reads 0
  function [7:0] trim_view;
    input [7:0] t;
    begin
      trim_view = {1'b0, t[`CDT_TRIM_MODE:`CDT_TRIM_CODE_LO]};
    end
  endfunction

  // ==========================================================
  // Bus handshake: one wait cycle, answer at the second edge
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_take = avs_write_in & ~ack_q;
  assign rd_take = avs_read_in & ~ack_q;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ==========================================================
  // Comparator 1 control register writes
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_take && hit_at(avs_address_in, `CDT_OFS_CMP1_CTRL)) begin
      ctrl_d = lane0(ctrl_q, avs_writedata_in, avs_byteenable_in);
    end
    // Status and unused bits are never stored
    ctrl_d[`CDT_CTRL_RAW] = 1'b0;
    ctrl_d[`CDT_CTRL_FILT] = 1'b0;
    ctrl_d[`CDT_CTRL_GAP] = 1'b0;
  end

  // ==========================================================
  // Trim register writes for both comparators
  always @* begin
    trim0_d = trim0_q;
    if (wr_take && hit_at(avs_address_in, `CDT_OFS_CMP0_TRIM)) begin
      trim0_d = lane0(trim0_q, avs_writedata_in, avs_byteenable_in);
    end
    trim0_d[`CDT_TRIM_GAP] = 1'b0;
  end

  always @* begin
    trim1_d = trim1_q;
    if (wr_take && hit_at(avs_address_in, `CDT_OFS_CMP1_TRIM)) begin
      trim1_d = lane0(trim1_q, avs_writedata_in, avs_byteenable_in);
    end
    trim1_d[`CDT_TRIM_GAP] = 1'b0;
  end

  // ==========================================================
  // Polarity register writes
  always @* begin
    pol_d = pol_q;
    if (wr_take && hit_at(avs_address_in, `CDT_OFS_CMP1_POL)) begin
      pol_d = lane0(pol_q, avs_writedata_in, avs_byteenable_in);
    end
    pol_d[`CDT_POL_GAP_HI:`CDT_POL_GAP_LO] = 7'h00;
  end

  // ==========================================================
  // Comparator 1 control storage
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= `CDT_RST_CMP1_CTRL;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Comparator 0 trim storage
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trim0_q <= `CDT_RST_TRIM;
    end else begin
      trim0_q <= trim0_d;
    end
  end

  // Comparator 1 trim storage
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trim1_q <= `CDT_RST_TRIM;
    end else begin
      trim1_q <= trim1_d;
    end
  end

  // Polarity storage
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pol_q <= `CDT_RST_POL;
    end else begin
      pol_q <= pol_d;
    end
  end

  // ==========================================================
  // Comparator level brought into the clock domain
  cdt_sync u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(cmp1_compare_in),
    .sync_out(cmp_sync)
  );

  // ==========================================================
  // Raw result with polarity and switch-off forcing
  assign inv_sel = pol_q[`CDT_POL_INV];
  assign cmp_forced = ctrl_q[`CDT_CTRL_ON] & cmp_sync;

  always @* begin
    raw_d = cmp_forced ^ inv_sel;
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
    end
  end

  // ==========================================================
  // Prior-sample count chosen by the filter length select
  always @* begin
    case (ctrl_q[`CDT_CTRL_FLEN_HI:`CDT_CTRL_FLEN_LO])
      `CDT_FLEN_NONE: begin
        run_len = `CDT_RUN_NONE;
      end
      `CDT_FLEN_SHORT: begin
        run_len = `CDT_RUN_SHORT;
      end
      `CDT_FLEN_MID: begin
        run_len = `CDT_RUN_MID;
      end
      default: begin
        run_len = `CDT_RUN_LONG;
      end
    endcase
  end

  // ==========================================================
  // Debounce filter; active level follows the invert setting
  cdt_filter #(
    .RUN_W(RUN_W)
  ) u_filter (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sample_in(raw_q),
    .active_level_in(~inv_sel),
    .run_len_in(run_len),
    .filt_out(filt)
  );

  // ==========================================================
  // Read views of each register
  assign ctrl_view = {raw_q, ctrl_q[`CDT_CTRL_ON], filt, 1'b0, ctrl_q[`CDT_CTRL_FLEN_HI:`CDT_CTRL_BIAS_LO]};
  assign trim0_view = trim_view(trim0_q);
  assign trim1_view = trim_view(trim1_q);
  assign pol_view = {7'h00, pol_q[`CDT_POL_INV]};

  // ==========================================================
  // Read data captured at the first request edge, zero if unmapped
  always @* begin
    rdata_d = rdata_q;
    if (rd_take) begin
      if (hit_at(avs_address_in, `CDT_OFS_CMP1_CTRL)) begin
        rdata_d = {24'h000000, ctrl_view};
      end else if (hit_at(avs_address_in, `CDT_OFS_CMP0_TRIM)) begin
        rdata_d = {24'h000000, trim0_view};
      end else if (hit_at(avs_address_in, `CDT_OFS_CMP1_TRIM)) begin
        rdata_d = {24'h000000, trim1_view};
      end else if (hit_at(avs_address_in, `CDT_OFS_CMP1_POL)) begin
        rdata_d = {24'h000000, pol_view};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_out = rdata_q;

  // ==========================================================
  // Comparator 1 analogue controls
  assign cmp1_switch_on_out = ctrl_q[`CDT_CTRL_ON];
  assign cmp1_bias_current_sel_out = ctrl_q[`CDT_CTRL_BIAS_HI:`CDT_CTRL_BIAS_LO];
  assign cmp1_trim_mode_sel_out = trim1_q[`CDT_TRIM_MODE];
  assign cmp1_trim_ref_sel_out = trim1_q[`CDT_TRIM_REF];
  assign cmp1_trim_code_out = trim1_q[`CDT_TRIM_CODE_HI:`CDT_TRIM_CODE_LO];
  assign cmp1_raw_result_out = raw_q;
  assign cmp1_filtered_result_out = filt;

  // ==========================================================
  // Comparator 0 calibration controls
  assign cmp0_trim_mode_sel_out = trim0_q[`CDT_TRIM_MODE];
  assign cmp0_trim_ref_sel_out = trim0_q[`CDT_TRIM_REF];
  assign cmp0_trim_code_out = trim0_q[`CDT_TRIM_CODE_HI:`CDT_TRIM_CODE_LO];

endmodule

`default_nettype wire

// *** testbench/cdt_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// Port relation checks
module cdt_checker (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic cmp1_switch_on_out,
  input wire logic [1:0] cmp1_bias_current_sel_out,
  input wire logic cmp1_raw_result_out,
  input wire logic cmp1_filtered_result_out,
  input wire logic [4:0] cmp0_trim_code_out,
  input wire logic [4:0] cmp1_trim_code_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // First cycle of an enabled write
  wire wr0 = avs_write_in && avs_waitrequest_out && avs_byteenable_in[0];
  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait over one cycle");
  property p_wait_idle;
    !avs_read_in && !avs_write_in |-> !avs_waitrequest_out;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait while idle");
  property p_rd_hi;
    avs_readdata_out[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_trim0;
    $changed(cmp0_trim_code_out) |-> $past(wr0 && avs_address_in == 4'h4);
  endproperty
  a_trim0: assert property (p_trim0) else $error("trim0 moved alone");
  property p_trim1;
    $changed(cmp1_trim_code_out) |-> $past(wr0 && avs_address_in == 4'h8);
  endproperty
  a_trim1: assert property (p_trim1) else $error("trim1 moved alone");
  property p_ctrl;
    $changed({cmp1_switch_on_out, cmp1_bias_current_sel_out}) |-> $past(wr0 && avs_address_in == 4'h0);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control moved alone");
  property p_off;
    !$past(cmp1_switch_on_out) && !$past(cmp1_switch_on_out, 2) && !$past(avs_write_in, 2)
      |-> $stable(cmp1_raw_result_out);
  endproperty
  a_off: assert property (p_off) else $error("raw moved while off");
  property p_filt_up;
    $rose(cmp1_filtered_result_out) && !$past(avs_write_in) && !$past(avs_write_in, 2)
      |-> $past(cmp1_raw_result_out);
  endproperty
  a_filt_up: assert property (p_filt_up) else $error("filter rose on low raw");
  c_filt_up: cover property ($rose(cmp1_filtered_result_out));
  c_filt_dn: cover property ($fell(cmp1_filtered_result_out));
  c_trim: cover property (wr0 && avs_address_in == 4'h4);
endmodule
bind cdt_top cdt_checker cdt_checker_i (.*);
`default_nettype wire

// *** testbench/cdt_cmp_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// Analogue comparator core
module cdt_cmp_model (
  input wire logic clk_in,
  input wire logic on_in,
  input wire logic [7:0] pos_in,
  input wire logic [7:0] neg_in,
  output logic res_out
);
  logic junk_q = 1'b0;
  // A core that is off gives no level to trust
  always @(posedge clk_in) junk_q <= ~junk_q;
  assign res_out = on_in ? (pos_in > neg_in) : junk_q;
endmodule
`default_nettype wire

// *** testbench/cdt_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module cdt_top_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 32'h0;
  logic [7:0] pos = 8'h40;
  logic [31:0] rdat;
  logic wq, cmp, on, raw, filt, m0, r0, m1, r1;
  logic [1:0] bias;
  logic [4:0] c0, c1;
  logic [7:0] v;
  int err_total = 0;
  int n_tests = 0;
  int d;
  int nv[4] = '{0, 31, 63, 126};
  // ====
  // Clock, device and partner
  always #12.5 clk = ~clk;
  cdt_top cdt_top_i (.clk_in(clk), .resetn_in(resetn), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .cmp1_compare_in(cmp), .cmp1_switch_on_out(on),
    .cmp1_bias_current_sel_out(bias), .cmp1_trim_mode_sel_out(m1), .cmp1_trim_ref_sel_out(r1),
    .cmp1_trim_code_out(c1), .cmp1_raw_result_out(raw), .cmp1_filtered_result_out(filt),
    .cmp0_trim_mode_sel_out(m0), .cmp0_trim_ref_sel_out(r0), .cmp0_trim_code_out(c0));
  cdt_cmp_model cdt_cmp_model_i (.clk_in(clk), .on_in(on), .pos_in(pos), .neg_in(8'h80), .res_out(cmp));
  // ====
  // Tasks
  task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // One bus cycle, held until wait is seen low at a rising edge
  task xfer(input logic w, input logic [3:0] a, input logic [7:0] dat, input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, dat};
    be <= b;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    v = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input string s, input logic [3:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00, 4'hf);
    chk(s, v, exp);
  endtask
  task set_in(input logic hi);
    @(posedge clk);
    pos <= hi ? 8'hc0 : 8'h40;
  endtask
  // Move the input, then time the filter from the raw change
  task meas(input logic hi, input logic lvl);
    set_in(hi);
    while (raw !== lvl) @(negedge clk);
    d = 0;
    while (filt !== lvl && d < 400) begin
      @(negedge clk);
      d++;
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ====
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    stop_test;
  end
  // ====
  // Tests
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rchk("ctrl rst", 4'h0, 8'h00);
    rchk("trim0 rst", 4'h4, 8'h10);
    rchk("trim1 rst", 4'h8, 8'h10);
    rchk("pol rst", 4'hc, 8'h00);
    $display("reset values done");
    xfer(1'b1, 4'h4, 8'hff, 4'hf);
    rchk("trim0", 4'h4, 8'h7f);
    chk("trim0 pins", {1'b0, m0, r0, c0}, 8'h7f);
    xfer(1'b1, 4'h4, 8'h00, 4'h0);
    rchk("trim0 lane off", 4'h4, 8'h7f);
    xfer(1'b1, 4'h4, 8'h13, 4'hf);
    chk("trim0 restore", {1'b0, m0, r0, c0}, 8'h13);
    xfer(1'b1, 4'h8, 8'hea, 4'hf);
    chk("trim1 pins", {1'b0, m1, r1, c1}, 8'h6a);
    rchk("trim1", 4'h8, 8'h6a);
    xfer(1'b1, 4'h2, 8'hff, 4'hf);
    rchk("unmapped", 4'h2, 8'h00);
    xfer(1'b1, 4'h0, 8'hff, 4'hf);
    chk("ctrl pins", {5'h0, on, bias}, 8'h07);
    xfer(1'b0, 4'h0, 8'h00, 4'hf);
    chk("ctrl rw", v & 8'h5f, 8'h4f);
    $display("registers done");
    xfer(1'b1, 4'h0, 8'h40, 4'hf);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 4'hc, {7'h0, i[1]}, 4'hf);
      set_in(i[0]);
      repeat (6) @(negedge clk);
      chk("raw on", {7'h0, raw}, {7'h0, i[0] ^ i[1]});
    end
    xfer(1'b1, 4'h0, 8'h00, 4'hf);
    for (int j = 0; j < 2; j++) begin
      xfer(1'b1, 4'hc, {7'h0, j[0]}, 4'hf);
      repeat (6) @(posedge clk);
      rchk("ctrl off", 4'h0, j[0] ? 8'ha0 : 8'h00);
    end
    xfer(1'b1, 4'hc, 8'h00, 4'hf);
    $display("raw result done");
    for (int k = 0; k < 4; k++) begin
      set_in(1'b0);
      repeat (140) @(posedge clk);
      xfer(1'b1, 4'h0, {4'h4, k[1:0], 2'h0}, 4'hf);
      if (k > 0) begin
        set_in(1'b1);
        repeat (nv[k] / 2) @(negedge clk);
        chk("filt early", {7'h0, filt}, 8'h00);
        set_in(1'b0);
        repeat (140) @(posedge clk);
      end
      meas(1'b1, 1'b1);
      chk("filt delay", {7'h0, d >= nv[k] && d <= nv[k] + 1}, 8'h01);
    end
    xfer(1'b1, 4'hc, 8'h01, 4'hf);
    rchk("pol", 4'hc, 8'h01);
    xfer(1'b1, 4'h0, 8'h44, 4'hf);
    set_in(1'b1);
    repeat (140) @(posedge clk);
    meas(1'b0, 1'b1);
    meas(1'b1, 1'b0);
    chk("inv delay", {7'h0, d >= 31 && d <= 32}, 8'h01);
    $display("filter done");
    stop_test;
  end
endmodule
`default_nettype wire
